//--- limit_compare_diag_flags_consts.svh
// limit_compare_diag_flags_consts.svh: offsets, field positions and reset values
// assumes: included by the limit-flag module only, 16-bit register words
// Functional notes
// R1: shunt above over threshold sets bit 6
// R2: shunt below under threshold sets bit 5
// R3: bus above over threshold sets bit 4
// R4: bus below under threshold sets bit 3
// R5: power above power limit sets bit 2
// R6: finished conversion sets bit 1
// R7: latched mode: diagnostic access clears limit flags
// R8: latched mode: triggered start clears conversion flag
// R9: bit 0 low on trim checksum error
// R10: negative over threshold trips at zero shunt
// R11: host sets over threshold above under threshold
// R12: shunt over threshold signed, reset 7fff
// R13: shunt under threshold signed, reset 8000
// R14: bus over threshold 15 bits, bit 15 zero
// R15: transparent follows fault; latched holds until access
// R16: range bit picks 5 or 1.25 uV scaling
// R17: compare once per result, flag same cycle; the flag register is set one cycle after the result strobe
// R18: reserved bits read zero, flags not writable
`ifndef LIMIT_COMPARE_DIAG_FLAGS_CONSTS_SVH
`define LIMIT_COMPARE_DIAG_FLAGS_CONSTS_SVH
`define OFF_DIAG 8'h0b
`define OFF_SHUNT_OVER 8'h0c
`define OFF_SHUNT_UNDER 8'h0d
`define OFF_BUS_OVER 8'h0e
`define OFF_BUS_UNDER 8'h0f
`define RST_SHUNT_OVER 16'h7fff
`define RST_SHUNT_UNDER 16'h8000
`define RST_BUS_OVER 15'h7fff
`define RST_BUS_UNDER 15'h0000
`define BIT_LATCH 15
`define BIT_CNVR_ALERT 14
`define BIT_SLOW_ALERT 13
`define BIT_ALERT_POLARITY 12
`define BIT_SHUNT_OVER 6
`define BIT_SHUNT_UNDER 5
`define BIT_BUS_OVER 4
`define BIT_BUS_UNDER 3
`define BIT_POWER_OVER 2
`define BIT_CONV_DONE 1
`define BIT_TRIM_OK 0
`define LSB_NV_WIDE 13'd5000
`define LSB_NV_FINE 13'd1250
`endif

//--- limit_flags_pkg.sv
// limit_flags_pkg.sv: types shared by the limit comparison block
// assumes: constants come from limit_compare_diag_flags_consts.svh
package limit_flags_pkg;
	typedef struct packed {
		logic shunt_over_flag;
		logic shunt_under_flag;
		logic bus_over_flag;
		logic bus_under_flag;
		logic power_over_flag;
		logic conversion_done_flag;
		logic trim_checksum_ok;
	} flags_t;
	typedef struct packed {
		logic flag_latch_enable;
		logic cnvr_alert;
		logic slow_alert;
		logic alert_polarity;
	} diag_cfg_t;
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [15:0] wdata;
	} reg_req_t;
endpackage : limit_flags_pkg

//--- limit_compare_diag_flags.sv
// limit_compare_diag_flags.sv: threshold registers, limit compare and diagnostic flags
// assumes: the i2c engine presents decoded register accesses on i_mclk,
// result strobes come from the conversion logic on the same clock
`timescale 1ns/1ps
`include "limit_compare_diag_flags_consts.svh"
module limit_compare_diag_flags
	import limit_flags_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire reg_req_t i_reg,
	output logic [15:0] o_reg_rdata,
	output logic o_reg_rvalid,
	input wire logic i_shunt_valid,
	input wire logic [15:0] i_shunt_result,
	input wire logic i_bus_valid,
	input wire logic [15:0] i_bus_result,
	input wire logic i_power_valid,
	input wire logic [23:0] i_power_result,
	input wire logic [15:0] i_power_limit,
	input wire logic i_conv_done,
	input wire logic i_conv_start,
	input wire logic i_trim_cksum_err,
	input wire logic i_shunt_range_select,
	output flags_t o_flags,
	output diag_cfg_t o_diag_cfg,
	output logic [12:0] o_shunt_lsb_nv
);

	function automatic logic hit_addr(input reg_req_t req, input logic [7:0] off);
		hit_addr = (req.wr || req.rd) && (req.addr == off);
	endfunction : hit_addr

	logic [15:0] shunt_over_threshold_r;
	logic [15:0] shunt_under_threshold_r;
	logic [14:0] bus_over_threshold_r;
	logic [14:0] bus_under_threshold_r;
	diag_cfg_t cfg_r;
	logic [4:0] lim_flag_r;
	logic conv_flag_r;
	logic trim_ok_r;
	logic [4:0] lim_valid;
	logic [4:0] lim_hit;
	logic diag_acc;
	logic [15:0] diag_word;
	logic [15:0] rdata_nxt;

	assign diag_acc = hit_addr(i_reg, `OFF_DIAG);

	// threshold registers; bus thresholds keep only 15 bits so bit 15 can never be set
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			shunt_over_threshold_r <= `RST_SHUNT_OVER; // R12
			shunt_under_threshold_r <= `RST_SHUNT_UNDER; // R13
			bus_over_threshold_r <= `RST_BUS_OVER; // R14
			bus_under_threshold_r <= `RST_BUS_UNDER;
		end else if (i_reg.wr) begin
			if (i_reg.addr == `OFF_SHUNT_OVER) begin
				shunt_over_threshold_r <= i_reg.wdata; // R12
			end
			if (i_reg.addr == `OFF_SHUNT_UNDER) begin
				shunt_under_threshold_r <= i_reg.wdata; // R13
			end
			if (i_reg.addr == `OFF_BUS_OVER) begin
				bus_over_threshold_r <= i_reg.wdata[14:0]; // R14
			end
			if (i_reg.addr == `OFF_BUS_UNDER) begin
				bus_under_threshold_r <= i_reg.wdata[14:0];
			end
		end
	end

	// only the configuration bits of the diagnostic word take host writes
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			cfg_r <= '0;
		end else if (i_reg.wr && i_reg.addr == `OFF_DIAG) begin
			cfg_r.flag_latch_enable <= i_reg.wdata[`BIT_LATCH]; // R18
			cfg_r.cnvr_alert <= i_reg.wdata[`BIT_CNVR_ALERT];
			cfg_r.slow_alert <= i_reg.wdata[`BIT_SLOW_ALERT];
			cfg_r.alert_polarity <= i_reg.wdata[`BIT_ALERT_POLARITY];
		end
	end

	// signed compare: a negative over threshold trips on a zero result
	assign lim_hit[4] = $signed(i_shunt_result) > $signed(shunt_over_threshold_r); // R1 R10
	assign lim_hit[3] = $signed(i_shunt_result) < $signed(shunt_under_threshold_r); // R2
	assign lim_hit[2] = i_bus_result > {1'b0, bus_over_threshold_r}; // R3
	assign lim_hit[1] = i_bus_result < {1'b0, bus_under_threshold_r}; // R4
	assign lim_hit[0] = i_power_result > {i_power_limit, 8'h00}; // R5
	assign lim_valid = {i_shunt_valid, i_shunt_valid, i_bus_valid, i_bus_valid, i_power_valid};

	// one slice per limit flag; a new hit wins over a clearing access in the same cycle
	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_lim
			always_ff @(posedge i_mclk) begin
				if (!i_rstn) begin
					lim_flag_r[g] <= 1'b0;
				end else if (!cfg_r.flag_latch_enable) begin
					if (lim_valid[g]) begin
						lim_flag_r[g] <= lim_hit[g]; // R15 R17
					end
				end else if (lim_valid[g] && lim_hit[g]) begin
					lim_flag_r[g] <= 1'b1; // R17
				end else if (diag_acc) begin
					lim_flag_r[g] <= 1'b0; // R7 R15
				end
			end
		end
	endgenerate

	// completion always wins over either clearing cause
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			conv_flag_r <= 1'b0;
		end else if (i_conv_done) begin
			conv_flag_r <= 1'b1; // R6
		end else if (diag_acc) begin
			conv_flag_r <= 1'b0; // R6
		end else if (cfg_r.flag_latch_enable && i_conv_start) begin
			conv_flag_r <= 1'b0; // R8
		end
	end

	// a checksum fault stays reported until the next reset
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			trim_ok_r <= 1'b1; // R9
		end else if (i_trim_cksum_err) begin
			trim_ok_r <= 1'b0; // R9
		end
	end

	always_comb begin
		diag_word = 16'h0000; // R18
		diag_word[`BIT_LATCH] = cfg_r.flag_latch_enable;
		diag_word[`BIT_CNVR_ALERT] = cfg_r.cnvr_alert;
		diag_word[`BIT_SLOW_ALERT] = cfg_r.slow_alert;
		diag_word[`BIT_ALERT_POLARITY] = cfg_r.alert_polarity;
		diag_word[`BIT_SHUNT_OVER] = lim_flag_r[4];
		diag_word[`BIT_SHUNT_UNDER] = lim_flag_r[3];
		diag_word[`BIT_BUS_OVER] = lim_flag_r[2];
		diag_word[`BIT_BUS_UNDER] = lim_flag_r[1];
		diag_word[`BIT_POWER_OVER] = lim_flag_r[0];
		diag_word[`BIT_CONV_DONE] = conv_flag_r;
		diag_word[`BIT_TRIM_OK] = trim_ok_r;
	end

	always_comb begin
		case (i_reg.addr)
			`OFF_DIAG: rdata_nxt = diag_word;
			`OFF_SHUNT_OVER: rdata_nxt = shunt_over_threshold_r;
			`OFF_SHUNT_UNDER: rdata_nxt = shunt_under_threshold_r;
			`OFF_BUS_OVER: rdata_nxt = {1'b0, bus_over_threshold_r}; // R14
			`OFF_BUS_UNDER: rdata_nxt = {1'b0, bus_under_threshold_r};
			default: rdata_nxt = 16'h0000;
		endcase
	end

	// read data is the word before any clear caused by the same read
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			o_reg_rdata <= 16'h0000;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg.rd;
			if (i_reg.rd) begin
				o_reg_rdata <= rdata_nxt;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			o_flags <= 7'h01; // R9
		end else begin
			o_flags <= {lim_flag_r, conv_flag_r, trim_ok_r};
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			o_diag_cfg <= '0;
		end else begin
			o_diag_cfg <= cfg_r;
		end
	end

	// thresholds are raw codes, so range only changes the reported weight of one step
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			o_shunt_lsb_nv <= `LSB_NV_WIDE;
		end else begin
			o_shunt_lsb_nv <= i_shunt_range_select ? `LSB_NV_FINE : `LSB_NV_WIDE; // R16
		end
	end

	property p_shunt_over;
		@(posedge i_mclk) disable iff (!i_rstn)
		i_shunt_valid && $signed(i_shunt_result) > $signed(shunt_over_threshold_r)
			|=> lim_flag_r[4] ##1 o_flags.shunt_over_flag;
	endproperty
	a_shunt_over: assert property (p_shunt_over) else $error("shunt over flag missed"); // R1

	property p_shunt_under;
		@(posedge i_mclk) disable iff (!i_rstn)
		i_shunt_valid && $signed(i_shunt_result) < $signed(shunt_under_threshold_r)
			|=> lim_flag_r[3];
	endproperty
	a_shunt_under: assert property (p_shunt_under) else $error("shunt under flag missed"); // R2

	property p_bus_over;
		@(posedge i_mclk) disable iff (!i_rstn)
		i_bus_valid && i_bus_result > {1'b0, bus_over_threshold_r} |=> lim_flag_r[2];
	endproperty
	a_bus_over: assert property (p_bus_over) else $error("bus over flag missed"); // R3

	property p_bus_under;
		@(posedge i_mclk) disable iff (!i_rstn)
		i_bus_valid && i_bus_result < {1'b0, bus_under_threshold_r} |=> lim_flag_r[1];
	endproperty
	a_bus_under: assert property (p_bus_under) else $error("bus under flag missed"); // R4

	property p_power_over;
		@(posedge i_mclk) disable iff (!i_rstn)
		i_power_valid && i_power_result > {i_power_limit, 8'h00} |=> lim_flag_r[0];
	endproperty
	a_power_over: assert property (p_power_over) else $error("power over flag missed"); // R5

	property p_conv_done;
		@(posedge i_mclk) disable iff (!i_rstn)
		i_conv_done |=> conv_flag_r ##1 o_flags.conversion_done_flag;
	endproperty
	a_conv_done: assert property (p_conv_done) else $error("conversion flag missed"); // R6

	property p_latch_clear;
		@(posedge i_mclk) disable iff (!i_rstn)
		cfg_r.flag_latch_enable && diag_acc && !(lim_valid[4] && lim_hit[4])
			|=> !lim_flag_r[4];
	endproperty
	a_latch_clear: assert property (p_latch_clear) else $error("access did not clear"); // R7

	property p_start_clear;
		@(posedge i_mclk) disable iff (!i_rstn)
		cfg_r.flag_latch_enable && i_conv_start && !i_conv_done |=> !conv_flag_r;
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("start did not clear"); // R8

	property p_trim;
		@(posedge i_mclk) disable iff (!i_rstn)
		i_trim_cksum_err |=> !trim_ok_r [*2];
	endproperty
	a_trim: assert property (p_trim) else $error("checksum error not shown"); // R9

	property p_trim_sticky;
		@(posedge i_mclk) disable iff (!i_rstn)
		!trim_ok_r |=> !trim_ok_r;
	endproperty
	a_trim_sticky: assert property (p_trim_sticky) else $error("checksum status recovered"); // R9

	property p_trim_out;
		@(posedge i_mclk) disable iff (!i_rstn)
		1'b1 |=> o_flags.trim_checksum_ok == $past(trim_ok_r);
	endproperty
	a_trim_out: assert property (p_trim_out) else $error("status bit not exported"); // R9

	property p_latch_hold;
		@(posedge i_mclk) disable iff (!i_rstn)
		cfg_r.flag_latch_enable && lim_flag_r[4] && !diag_acc
			&& $stable(cfg_r.flag_latch_enable) |=> lim_flag_r[4];
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latched flag dropped"); // R15

	property p_transparent;
		@(posedge i_mclk) disable iff (!i_rstn)
		!cfg_r.flag_latch_enable && i_bus_valid && !lim_hit[2] |=> !lim_flag_r[2];
	endproperty
	a_transparent: assert property (p_transparent) else $error("flag did not return"); // R15

	property p_reserved;
		@(posedge i_mclk) disable iff (!i_rstn)
		i_reg.rd && i_reg.addr == `OFF_DIAG |=> o_reg_rvalid && o_reg_rdata[11:7] == 5'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // R18

	property p_bus_bit15;
		@(posedge i_mclk) disable iff (!i_rstn)
		i_reg.rd && i_reg.addr == `OFF_BUS_OVER |=> !o_reg_rdata[15];
	endproperty
	a_bus_bit15: assert property (p_bus_bit15) else $error("bus threshold bit 15 set"); // R14

	property p_over_readback;
		@(posedge i_mclk) disable iff (!i_rstn)
		// a host may leave one idle cycle between the write and the read back
		i_reg.wr && i_reg.addr == `OFF_SHUNT_OVER ##1 !i_reg.wr ##1 i_reg.rd && !i_reg.wr
			&& i_reg.addr == `OFF_SHUNT_OVER |=> o_reg_rdata == $past(i_reg.wdata, 3);
	endproperty
	a_over_readback: assert property (p_over_readback) else $error("threshold readback"); // R12

	property p_range;
		@(posedge i_mclk) disable iff (!i_rstn)
		i_shunt_range_select |=> o_shunt_lsb_nv == `LSB_NV_FINE;
	endproperty
	a_range: assert property (p_range) else $error("range weight wrong"); // R16

endmodule : limit_compare_diag_flags

//--- lcdf_host_model.sv
// lcdf_host_model.sv: register-port host standing in for the serial engine
// assumes: requests taken on rising i_mclk, driven here on the falling edge
`timescale 1ns/1ps
module lcdf_host_model
	import limit_flags_pkg::*;
(
	input wire logic i_mclk,
	output reg_req_t o_reg
);
	initial o_reg = '0;
	// one-cycle request; released lines carry inverted junk so stale values are never trusted
	task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] data);
		@(negedge i_mclk);
		o_reg <= '{addr: addr, wr: wr, rd: ~wr, wdata: data};
		@(negedge i_mclk);
		o_reg <= '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~data};
	endtask : access
endmodule : lcdf_host_model

//--- limit_compare_diag_flags_tb_top.sv
// limit_compare_diag_flags_tb_top.sv: self-checking bench for the limit flag block
// assumes: host model drives the register port, result strobes come from here
`timescale 1ns/1ps
module limit_compare_diag_flags_tb_top
	import limit_flags_pkg::*;
;
	logic i_mclk, i_rstn, sh_v, bu_v, pw_v, cd, cs, cerr, rng, rvalid;
	logic [15:0] sh, bu, lim, rdata;
	logic [23:0] pw;
	logic [12:0] lsb;
	reg_req_t req;
	flags_t flg;
	diag_cfg_t cfgo;
	logic [15:0] exp_q[$];
	int fail_count, tests_run;

	limit_compare_diag_flags u_limit_compare_diag_flags (.i_mclk(i_mclk), .i_rstn(i_rstn),
		.i_reg(req), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_shunt_valid(sh_v),
		.i_shunt_result(sh), .i_bus_valid(bu_v), .i_bus_result(bu), .i_power_valid(pw_v),
		.i_power_result(pw), .i_power_limit(lim), .i_conv_done(cd), .i_conv_start(cs),
		.i_trim_cksum_err(cerr), .i_shunt_range_select(rng), .o_flags(flg), .o_diag_cfg(cfgo),
		.o_shunt_lsb_nv(lsb));
	lcdf_host_model u_lcdf_host_model (.i_mclk(i_mclk), .o_reg(req));

	task automatic report_and_stop();
		if (fail_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	task automatic compare(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : compare

	task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
		exp_q.push_back(exp);
		u_lcdf_host_model.access(1'b0, addr, 16'h0000);
	endtask : rd

	task automatic wr(input logic [7:0] addr, input logic [15:0] data);
		u_lcdf_host_model.access(1'b1, addr, data);
	endtask : wr

	// en = {shunt, bus, power, conv done, conv start}
	task automatic pulse(input logic [4:0] en, input logic [15:0] s, input logic [15:0] b,
		input logic [23:0] p);
		@(negedge i_mclk);
		{sh_v, bu_v, pw_v, cd, cs} = en;
		sh = s;
		bu = b;
		pw = p;
		@(negedge i_mclk);
		{sh_v, bu_v, pw_v, cd, cs} = 5'h00;
	endtask : pulse

	// read data is judged mid-cycle while rvalid stands, oldest expectation first
	always @(negedge i_mclk) begin
		if (rvalid === 1'b1)
			compare(rdata, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
	end

	initial begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end

	initial begin
		#2000000;
		fail_count++;
		report_and_stop();
	end

	initial begin
		logic [15:0] s, b;
		logic [23:0] p;
		{i_rstn, sh_v, bu_v, pw_v, cd, cs, cerr, rng} = 8'h00;
		{sh, bu, lim, pw} = '0;
		void'($urandom(59395));
		repeat (3) @(negedge i_mclk);
		i_rstn = 1'b1;
		rd(8'h0c, 16'h7fff);
		rd(8'h0d, 16'h8000);
		rd(8'h0e, 16'h7fff);
		rd(8'h0f, 16'h0000);
		rd(8'h0b, 16'h0001);
		wr(8'h20, 16'hbeef);
		rd(8'h20, 16'h0000);
		wr(8'h0e, 16'hffff);
		rd(8'h0e, 16'h7fff);
		wr(8'h0b, 16'hffff);
		rd(8'h0b, 16'hf001);
		compare({12'h000, cfgo}, 16'h000f);
		wr(8'h0b, 16'h0000);
		s = $urandom;
		wr(8'h0c, s);
		rd(8'h0c, s);
		wr(8'h0c, 16'hfff0);
		wr(8'h0d, 16'hffe0);
		pulse(5'b10000, 16'h0000, 16'h0000, 24'h000000);
		rd(8'h0b, 16'h0041);
		wr(8'h0c, 16'h0100);
		wr(8'h0d, 16'hff00);
		wr(8'h0e, 16'h1000);
		wr(8'h0f, 16'h0800);
		for (int i = 0; i < 16; i++) begin
			s = ($urandom & 16'h03ff) - 16'h0200;
			b = 16'h0400 + ($urandom & 16'h0fff);
			p = $urandom & 24'h03ffff;
			lim = $urandom & 16'h03ff;
			pulse(5'b11110, s, b, p);
			rd(8'h0b, {9'h000, $signed(s) > $signed(16'h0100), $signed(s) < $signed(16'hff00),
				b > 16'h1000, b < 16'h0800, p > {lim, 8'h00}, 2'b11});
		end
		pulse(5'b11100, 16'h0000, 16'h0c00, 24'h000000);
		rd(8'h0b, 16'h0001);
		wr(8'h0b, 16'h8000);
		pulse(5'b10000, 16'h0200, 16'h0000, 24'h000000);
		pulse(5'b10000, 16'h0000, 16'h0000, 24'h000000);
		compare({9'h000, flg}, 16'h0041);
		compare({12'h000, cfgo}, 16'h0008);
		rd(8'h0b, 16'h8041);
		rd(8'h0b, 16'h8001);
		pulse(5'b01000, 16'h0000, 16'h0200, 24'h000000);
		wr(8'h0b, 16'h8000);
		rd(8'h0b, 16'h8001);
		pulse(5'b00010, 16'h0000, 16'h0000, 24'h000000);
		pulse(5'b00001, 16'h0000, 16'h0000, 24'h000000);
		rd(8'h0b, 16'h8001);
		pulse(5'b00010, 16'h0000, 16'h0000, 24'h000000);
		rd(8'h0b, 16'h8003);
		for (int r = 0; r < 2; r++) begin
			@(negedge i_mclk);
			rng = r[0];
			repeat (3) @(negedge i_mclk);
			compare({3'b000, lsb}, r ? 16'h04e2 : 16'h1388);
		end
		wr(8'h0b, 16'h0000);
		@(negedge i_mclk);
		cerr = 1'b1;
		@(negedge i_mclk);
		cerr = 1'b0;
		rd(8'h0b, 16'h0000);
		compare({9'h000, flg}, 16'h0000);
		@(negedge i_mclk);
		i_rstn = 1'b0;
		repeat (3) @(negedge i_mclk);
		i_rstn = 1'b1;
		rd(8'h0b, 16'h0001);
		for (int k = 0; k < 20 && exp_q.size() > 0; k++)
			@(negedge i_mclk);
		if (exp_q.size() != 0)
			fail_count++;
		report_and_stop();
	end
endmodule : limit_compare_diag_flags_tb_top
